// ---- hw/npd_pkg.sv ----
// Purpose: constants and types for the nibble-prefix instruction decoder
// Assumes: 16-bit words, byte-wide instructions
// Notes: none
package npd_pkg;
    localparam int WORD_W = 16;
    localparam logic [3:0] FN_JUMP = 4'h0;
    localparam logic [3:0] FN_PFIX = 4'h2;
    localparam logic [3:0] FN_LDC = 4'h4;
    localparam logic [3:0] FN_NFIX = 4'h6;
    localparam logic [3:0] FN_OPR = 4'hF;
    localparam logic [15:0] OP_SHL = 16'h0041;
    localparam logic [15:0] OP_SHR = 16'h0040;
    localparam logic [15:0] OP_PROD = 16'h0008;
    localparam logic [15:0] OP_MOVE = 16'h004A;
    localparam logic [15:0] OP_DEVID = 16'h017C;
    localparam logic [15:0] OP_FPENTRY = 16'h00AB;
    localparam logic [15:0] OP_BRK_ENABLE = 16'h00B1;
    localparam logic [15:0] DEVID_VAL = 16'h00C3; // arbitrary identity value
    localparam logic [7:0] BASE_CYC = 8'h01;
    localparam logic [7:0] SHIFT_CYC = 8'h02;
    localparam logic [7:0] PROD_CYC = 8'h04;
    localparam logic [7:0] MOVE_CYC = 8'h08;
    localparam logic [7:0] JUMP_CYC = 8'h03;
    localparam logic [1:0] BYTES_PER_WORD = 2'h2;
    typedef enum logic [2:0] {
        NPD_K_NONE, NPD_K_FUNC, NPD_K_OPR, NPD_K_DEVID, NPD_K_FPSEL, NPD_K_BREAK, NPD_K_NOP
    } npd_kind_type;
endpackage

// ---- hw/npd_time_if.sv ----
// Purpose: carries timing request from decoder to cycle counter
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
interface npd_time_if;
    logic [15:0] op;
    logic [15:0] areg;
    logic [15:0] msg_len;
    logic [15:0] msg_addr;
    logic prefixed;
    logic is_opr;
    logic [7:0] cycles;
    modport dec (output op, areg, msg_len, msg_addr, prefixed, is_opr, input cycles);
    modport cnt (input op, areg, msg_len, msg_addr, prefixed, is_opr, output cycles);
endinterface

// ---- hw/npd_cycle_calc.sv ----
// Purpose: computes cycle count of a decoded instruction
// Assumes: internal memory timing
// Notes: combinational
`timescale 1ns/1ps
module npd_cycle_calc (
    npd_time_if.cnt t
);
    // ****************
    // highest set bit
    // ****************
    function automatic logic [7:0] msb_pos(input logic [15:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                r = 8'(i);
            end
        end
        return r;
    endfunction

    logic [16:0] span;
    logic [7:0] words;
    logic [7:0] base;
    always_comb begin
        span = {1'b0, t.msg_len} + {16'h0000, t.msg_addr[0]} + 17'h00001;
        words = span[8:1]; // part words at both ends counted whole
        if (!t.is_opr) begin
            base = npd_pkg::BASE_CYC; // non-operate base time
        end else if (t.op == npd_pkg::OP_SHL || t.op == npd_pkg::OP_SHR) begin
            base = t.areg[7:0] + npd_pkg::SHIFT_CYC; // places shifted
        end else if (t.op == npd_pkg::OP_PROD) begin
            base = msb_pos(t.areg) + npd_pkg::PROD_CYC;
        end else if (t.op == npd_pkg::OP_MOVE) begin
            base = {words[6:0], 1'b0} + npd_pkg::MOVE_CYC;
        end else begin
            base = npd_pkg::BASE_CYC;
        end
        t.cycles = base + {7'h00, t.prefixed}; // prefix adds one cycle
    end

endmodule

// ---- hw/npd_decoder.sv ----
// Purpose: byte-wide instruction decoder with prefix operand assembly
//          builds operands from prefix chains, classifies the finished instruction
//          and reports its cycle count to the execution datapath
// Assumes: one instruction byte per valid cycle, register A supplied by datapath
//          all inputs synchronous to i_mclk, reset synchronous and active low
// Notes: results registered one cycle after the byte
//        prefix bytes give no valid pulse; they only load the operand register and set the prefixed flag
//        breakpoint enable is sticky until reset
`timescale 1ns/1ps
module npd_decoder (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    input wire logic [15:0] i_areg,
    input wire logic [15:0] i_msg_len,
    output logic o_valid,
    output logic [3:0] o_func,
    output logic [15:0] o_operand,
    output logic [2:0] o_kind,
    output logic o_push_a,
    output logic [15:0] o_push_val,
    output logic [15:0] o_fp_sel,
    output logic o_swap_ptrs,
    output logic o_break_en,
    output logic [7:0] o_cycles
);
    typedef struct packed {
        logic [15:0] oreg;
        logic pre;
        logic valid;
        logic [3:0] func;
        logic [15:0] operand;
        npd_pkg::npd_kind_type kind;
        logic push_a;
        logic [15:0] push_val;
        logic [15:0] fp_sel;
        logic swap;
        logic brk_en;
        logic [7:0] cycles;
    } npd_state_type;

    npd_state_type st_ff;
    npd_state_type nxt_st;
    npd_time_if t ();
    logic [15:0] full;
    logic [3:0] fn;
    logic take_prefix;
    logic take_instr;
    npd_pkg::npd_kind_type op_kind;

    // ****************
    // prefix test
    // ****************
    // true for both operand-extend prefixes
    function automatic logic is_prefix(input logic [3:0] f);
        return (f == npd_pkg::FN_PFIX) || (f == npd_pkg::FN_NFIX);
    endfunction

    // ****************
    // prefix step
    // ****************
    // optional complement, then one nibble up
    function automatic logic [15:0] prefix_next(input logic [15:0] v, input logic neg);
        logic [15:0] m;
        m = neg ? ~v : v;
        return {m[11:0], 4'h0};
    endfunction

    // ****************
    // operate class
    // ****************
    // class of an operate instruction from its assembled code
    function automatic npd_pkg::npd_kind_type opr_kind(input logic [15:0] code);
        npd_pkg::npd_kind_type k;
        if (code == npd_pkg::OP_DEVID) begin
            k = npd_pkg::NPD_K_DEVID;
        end else if (code == npd_pkg::OP_FPENTRY) begin
            k = npd_pkg::NPD_K_FPSEL;
        end else begin
            k = npd_pkg::NPD_K_OPR;
        end
        return k;
    endfunction

    // ****************
    // zero-offset jump test
    // ****************
    // jump function with a zero operand
    function automatic logic is_zero_jump(input logic [3:0] f, input logic [15:0] v);
        return (f == npd_pkg::FN_JUMP) && (v == 16'h0000);
    endfunction

    // ****************
    // cycle counter
    // ****************

    npd_cycle_calc u_cyc (
        .t(t)
    );

    // ****************
    // operand assembly
    // ****************
    assign fn = i_byte[7:4];
    assign take_prefix = i_byte_valid && is_prefix(fn);
    assign take_instr = i_byte_valid && !is_prefix(fn);
    assign full = st_ff.oreg | {12'h000, i_byte[3:0]}; // low nibble joins operand
    assign op_kind = opr_kind(full);

    // ****************
    // cycle counter link
    // ****************
    assign t.op = full;
    assign t.areg = i_areg;
    assign t.msg_len = i_msg_len;
    assign t.msg_addr = i_areg;
    assign t.prefixed = st_ff.pre;
    assign t.is_opr = (fn == npd_pkg::FN_OPR);

    // ****************
    // decode
    // ****************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.valid = 1'b0;
        nxt_st.push_a = 1'b0;
        nxt_st.swap = 1'b0;
        if (take_prefix) begin
            if (fn == npd_pkg::FN_NFIX) begin
                nxt_st.oreg = prefix_next(full, 1'b1); // complement for negatives
            end else begin
                nxt_st.oreg = prefix_next(full, 1'b0); // msb nibble first
            end
            nxt_st.pre = 1'b1;
        end else if (take_instr) begin
            nxt_st.valid = 1'b1; // one byte is a whole instruction
            nxt_st.func = fn;
            nxt_st.operand = full;
            nxt_st.cycles = t.cycles;
            nxt_st.oreg = 16'h0000; // operand consumed
            nxt_st.pre = 1'b0;
            nxt_st.kind = npd_pkg::NPD_K_FUNC;
            if (fn == npd_pkg::FN_OPR) begin
                nxt_st.kind = op_kind; // short and extended ops
                if (op_kind == npd_pkg::NPD_K_DEVID) begin
                    nxt_st.push_a = 1'b1;
                    nxt_st.push_val = npd_pkg::DEVID_VAL;
                end else if (op_kind == npd_pkg::NPD_K_FPSEL) begin
                    nxt_st.fp_sel = i_areg; // selector loaded by prior load-constant
                end else if (full == npd_pkg::OP_BRK_ENABLE) begin
                    nxt_st.brk_en = 1'b1;
                end
            end else if (is_zero_jump(fn, full)) begin
                nxt_st.kind = st_ff.brk_en ? npd_pkg::NPD_K_BREAK : npd_pkg::NPD_K_NOP;
                nxt_st.swap = st_ff.brk_en;
            end
        end
    end

    // ****************
    // state register
    // ****************
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************
    // outputs
    // ****************
    // every output comes straight from the state register
    assign o_valid = st_ff.valid;
    assign o_func = st_ff.func;
    assign o_operand = st_ff.operand;
    assign o_kind = st_ff.kind;
    assign o_push_a = st_ff.push_a;
    assign o_push_val = st_ff.push_val;
    assign o_fp_sel = st_ff.fp_sel;
    assign o_swap_ptrs = st_ff.swap;
    assign o_break_en = st_ff.brk_en;
    assign o_cycles = st_ff.cycles;
endmodule

// ---- test/npd_imem.sv ----
// Purpose: instruction memory model feeding bytes
// Assumes: bench pushes bytes into q
// Notes: idle byte lines toggle
`timescale 1ns/1ps
module npd_imem (
    input wire logic i_mclk,
    output logic o_valid,
    output logic [7:0] o_byte
);
    logic [7:0] q[$];
    initial begin
        o_valid = 1'b0;
        o_byte = 8'h00;
    end
    always @(posedge i_mclk) begin
        if (q.size() > 0) begin
            o_valid <= 1'b1;
            o_byte <= q.pop_front();
        end else begin
            o_valid <= 1'b0;
            o_byte <= ~o_byte;
        end
    end
endmodule

// ---- test/npd_decoder_chk.sv ----
// Purpose: port checks of npd_decoder
// Assumes: single clock
// Notes: bound below
`timescale 1ns/1ps
module npd_decoder_chk (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    input wire logic [15:0] i_areg,
    input wire logic o_valid,
    input wire logic [3:0] o_func,
    input wire logic [15:0] o_operand,
    input wire logic o_push_a,
    input wire logic [15:0] o_push_val,
    input wire logic [15:0] o_fp_sel,
    input wire logic o_swap_ptrs,
    input wire logic o_break_en
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    wire logic is_pre = i_byte[7:4] == 4'h2 || i_byte[7:4] == 4'h6;
    sequence s_two(f);
        i_byte_valid && !is_pre ##1 i_byte_valid && i_byte[7:4] == f ##1 i_byte_valid && !is_pre;
    endsequence
    a_prefix_silent: assert property (i_byte_valid && is_pre |=> !o_valid)
        else $error("prefix gave valid");
    a_single_byte: assert property (i_byte_valid && !is_pre |=> o_valid && o_func == $past(i_byte[7:4]))
        else $error("byte not decoded");
    a_idle_quiet: assert property (!i_byte_valid |=> !o_valid)
        else $error("valid without byte");
    a_pfix_order: assert property (s_two(4'h2) |=> o_operand == {8'h00, $past(i_byte[3:0], 2), $past(i_byte[3:0])})
        else $error("prefix operand");
    a_nfix_neg: assert property (s_two(4'h6) |=> o_operand == {8'hFF, ~$past(i_byte[3:0], 2), $past(i_byte[3:0])})
        else $error("negative operand");
    a_devid_push: assert property (o_valid && o_func == 4'hF && o_operand == npd_pkg::OP_DEVID |-> o_push_a)
        else $error("identity push");
    a_fp_select: assert property (o_valid && o_func == 4'hF && o_operand == npd_pkg::OP_FPENTRY |-> o_fp_sel == $past(i_areg))
        else $error("fp selector");
    a_break_swap: assert property (o_valid && o_func == 4'h0 && o_operand == 16'h0000 |-> o_swap_ptrs == o_break_en)
        else $error("jump zero swap");
endmodule
bind npd_decoder npd_decoder_chk chk (.*);

// ---- test/npd_decoder_tb.sv ----
// Purpose: self-checking bench of npd_decoder
// Assumes: bytes come from npd_imem
// Notes: pulses checked here and by the checker
`timescale 1ns/1ps
module npd_decoder_tb;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [15:0] areg = 16'h0000;
    logic [15:0] len = 16'h0000;
    logic bv;
    logic [7:0] bt;
    logic [3:0] func;
    logic [15:0] opnd, pval, fsel;
    logic [2:0] kind;
    logic brk;
    logic vld, pusha, swp;
    logic [7:0] cyc;
    int err_count = 0;
    int checked = 0;
    always #2 i_mclk = ~i_mclk;
    npd_imem mem (.i_mclk(i_mclk), .o_valid(bv), .o_byte(bt));
    npd_decoder uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_byte_valid(bv), .i_byte(bt), .i_areg(areg),
        .i_msg_len(len), .o_valid(vld), .o_func(func), .o_operand(opnd), .o_kind(kind), .o_push_a(pusha),
        .o_push_val(pval), .o_fp_sel(fsel), .o_swap_ptrs(swp), .o_break_en(brk), .o_cycles(cyc));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic run(input logic [23:0] b, input int n, input logic [15:0] op, input logic [2:0] k,
        input logic [7:0] cy);
        @(negedge i_mclk);
        for (int i = n - 1; i >= 0; i--) mem.q.push_back(b[i*8 +: 8]);
        repeat (n + 1) @(posedge i_mclk);
        #1;
        chk("valid", 16'h0001, {15'h0, vld});
        chk("push_a", {15'h0, k == 3'h3}, {15'h0, pusha});
        chk("swap", {15'h0, k == 3'h5}, {15'h0, swp});
        @(posedge i_mclk);
        #1;
        chk("valid end", 16'h0000, {15'h0, vld});
        chk("func", {12'h000, b[7:4]}, {12'h000, func});
        chk("operand", op, opnd);
        chk("kind", {13'h0, k}, {13'h0, kind});
        chk("cycles", {8'h00, cy}, {8'h00, cyc});
    endtask
    task t_prefix;
        run(24'h432345, 3, 16'h0035, 3'h1, 8'h02);
        run(24'h436141, 3, 16'hFFE1, 3'h1, 8'h02);
    endtask
    task t_operate;
        run(24'h0000F5, 1, 16'h0005, 3'h2, 8'h01);
        run(24'h0021F6, 2, 16'h0016, 3'h2, 8'h02);
    endtask
    task t_devid_fp;
        run(24'h2127FC, 3, 16'h017C, 3'h3, 8'h02);
        chk("identity", npd_pkg::DEVID_VAL, pval);
        @(posedge i_mclk) areg <= 16'h0009;
        run(24'h492AFB, 3, 16'h00AB, 3'h4, 8'h02);
        chk("selector", 16'h0009, fsel);
    endtask
    task t_timing;
        @(posedge i_mclk) areg <= 16'h0100;
        run(24'h0000F8, 1, 16'h0008, 3'h2, 8'h0C);
        @(posedge i_mclk) areg <= 16'h0005;
        run(24'h0024F1, 2, 16'h0041, 3'h2, 8'h08);
        @(posedge i_mclk) begin
            areg <= 16'h0001;
            len <= 16'h0005;
        end
        run(24'h0024FA, 2, 16'h004A, 3'h2, 8'h0F);
    endtask
    task t_break;
        run(24'h000000, 1, 16'h0000, 3'h6, 8'h01);
        run(24'h002BF1, 2, 16'h00B1, 3'h2, 8'h02);
        chk("break_en", 16'h0001, {15'h0, brk});
        run(24'h000000, 1, 16'h0000, 3'h5, 8'h01);
    endtask
    task final_report;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        #1;
        chk("reset valid", 16'h0000, {15'h0, vld});
        chk("reset operand", 16'h0000, opnd);
        t_prefix;
        t_operate;
        t_devid_fp;
        t_timing;
        t_break;
        final_report;
    end
    initial begin
        #4000;
        err_count++;
        final_report;
    end
endmodule
